// ### hw/iefr_pkg.sv
/*
 * Constants and types for the interrupt enable and flag register block.
 * Assumes an APB master on pclk and event pulses from the on-chip sources.
 */
`default_nettype none
package iefr_pkg;

  localparam logic [7:0]  idx_control_bank0  = 8'h0b;
  localparam logic [7:0]  idx_control_bank1  = 8'h8b;
  // Byte address is four times the register index
  localparam logic [11:0] addr_control_bank0 = {2'b00, idx_control_bank0, 2'b00};
  localparam logic [11:0] addr_control_bank1 = {2'b00, idx_control_bank1, 2'b00};
  localparam logic [11:0] addr_ev_status     = 12'h100;
  localparam logic [11:0] addr_ev_mask       = 12'h104;
  localparam logic [11:0] addr_pc_pushed     = 12'h108;

  localparam int          bit_global_en      = 7;
  localparam int          bit_nvdata_en      = 6;
  localparam int          bit_timer_en       = 5;
  localparam int          bit_edge_en        = 4;
  localparam int          bit_port_en        = 3;
  localparam int          bit_timer_flag     = 2;
  localparam int          bit_edge_flag      = 1;
  localparam int          bit_port_flag      = 0;

  localparam logic [7:0]  control_reset      = 8'h00;
  localparam logic [3:0]  ev_reset           = 4'h0;
  localparam logic [12:0] pc_reset           = 13'h0000;
  localparam int          pc_width           = 13;
  localparam int          ev_count           = 4;
  localparam logic [31:0] rdata_reset        = 32'h00000000;

  typedef struct packed {
    logic nvdata_write_done;
    logic timer_overflow;
    logic edge_event;
    logic port_change;
  } iefr_events_type;

endpackage
`default_nettype wire

// ### hw/iefr_top.sv
/*
 * Interrupt control register with APB slave, event status and mask,
 * interrupt request and program counter push on acknowledge.
 * Assumes pclk at 125 MHz and source pulses synchronous to pclk.
 */
`default_nettype none
module iefr_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire iefr_pkg::iefr_events_type source_events,
  input  wire logic                    core_irq_ack,
  input  wire logic [12:0]             core_pc,
  output logic                         core_irq_request,
  output logic                         stack_push,
  output logic      [12:0]             stack_push_data,
  output logic                         irq
);

  // ****************************************************************
  // Storage and next values
  // ****************************************************************
  logic [7:0]                    interrupt_control;
  logic [iefr_pkg::ev_count-1:0] ev_status;
  logic [iefr_pkg::ev_count-1:0] ev_mask;
  logic [iefr_pkg::pc_width-1:0] pc_pushed;

  logic [7:0]                    next_control;
  wire  [iefr_pkg::ev_count-1:0] next_status;
  logic [iefr_pkg::ev_count-1:0] next_mask;
  logic [iefr_pkg::pc_width-1:0] next_pc_pushed;
  logic                          next_stack_push;
  logic [iefr_pkg::pc_width-1:0] next_stack_push_data;
  logic [31:0]                   next_prdata;

  // ****************************************************************
  // Address decode helpers
  // ****************************************************************
  // Both bank addresses reach one and the same control storage
  function automatic logic fn_is_control(input logic [11:0] addr);
    return (addr == iefr_pkg::addr_control_bank0) ||
           (addr == iefr_pkg::addr_control_bank1);
  endfunction

  function automatic logic fn_is_mapped(input logic [11:0] addr);
    return fn_is_control(addr) ||
           (addr == iefr_pkg::addr_ev_status) ||
           (addr == iefr_pkg::addr_ev_mask) ||
           (addr == iefr_pkg::addr_pc_pushed);
  endfunction

  // Unused upper bits read as zero
  function automatic logic [31:0] fn_read_word(
    input logic [11:0]                   addr,
    input logic [7:0]                    control,
    input logic [iefr_pkg::ev_count-1:0] status,
    input logic [iefr_pkg::ev_count-1:0] mask,
    input logic [iefr_pkg::pc_width-1:0] pc
  );
    logic [31:0] word;
    word = iefr_pkg::rdata_reset;
    if (fn_is_control(addr)) begin
      word[7:0] = control;
    end else if (addr == iefr_pkg::addr_ev_status) begin
      word[iefr_pkg::ev_count-1:0] = status;
    end else if (addr == iefr_pkg::addr_ev_mask) begin
      word[iefr_pkg::ev_count-1:0] = mask;
    end else if (addr == iefr_pkg::addr_pc_pushed) begin
      word[iefr_pkg::pc_width-1:0] = pc;
    end
    return word;
  endfunction

  // ****************************************************************
  // Bus phases and strobes
  // ****************************************************************
  wire setup_phase  = psel && !penable;
  wire access_phase = psel && penable;
  wire read_setup   = setup_phase && !pwrite;
  wire lane0_valid  = pstrb[0];
  wire hit_control  = fn_is_control(paddr);
  wire hit_status   = paddr == iefr_pkg::addr_ev_status;
  wire hit_mask     = paddr == iefr_pkg::addr_ev_mask;
  wire mapped       = fn_is_mapped(paddr);
  wire wr           = access_phase && pwrite && mapped && lane0_valid;
  wire wr_control   = wr && hit_control;
  wire wr_status    = wr && hit_status;
  wire wr_mask      = wr && hit_mask;

  wire [31:0] read_word = fn_read_word(paddr, interrupt_control, ev_status, ev_mask,
                                       pc_pushed);

  // Zero wait states: every access ends in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access_phase && !mapped;

  // ****************************************************************
  // Control register fields and event inputs
  // ****************************************************************
  wire global_irq_enable            = interrupt_control[iefr_pkg::bit_global_en];
  wire nvdata_write_done_irq_enable = interrupt_control[iefr_pkg::bit_nvdata_en];
  wire timer_overflow_irq_enable    = interrupt_control[iefr_pkg::bit_timer_en];
  wire edge_pin_irq_enable          = interrupt_control[iefr_pkg::bit_edge_en];
  wire port_change_irq_enable       = interrupt_control[iefr_pkg::bit_port_en];
  wire timer_overflow_flag          = interrupt_control[iefr_pkg::bit_timer_flag];
  wire edge_pin_flag                = interrupt_control[iefr_pkg::bit_edge_flag];
  wire port_change_flag             = interrupt_control[iefr_pkg::bit_port_flag];

  wire ev_nvdata = source_events.nvdata_write_done;
  wire ev_timer  = source_events.timer_overflow;
  wire ev_edge   = source_events.edge_event;
  wire ev_port   = source_events.port_change;

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_comb begin
    next_control = interrupt_control;
    if (wr_control) begin
      next_control = pwdata[7:0];
    end
    // Hardware set wins over a software clear in the same cycle
    if (ev_timer) begin
      next_control[iefr_pkg::bit_timer_flag] = 1'b1;
    end
    if (ev_edge) begin
      next_control[iefr_pkg::bit_edge_flag] = 1'b1;
    end
    if (ev_port) begin
      next_control[iefr_pkg::bit_port_flag] = 1'b1;
    end
  end

  // Bit zero has no defined reset value; zero is one legal choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control <= iefr_pkg::control_reset;
    end else begin
      interrupt_control <= next_control;
    end
  end

  // ****************************************************************
  // Request to the core
  // ****************************************************************
  // The write-complete source has no flag of its own: its level is used
  wire nvdata_pending = nvdata_write_done_irq_enable && ev_nvdata;
  wire timer_pending  = timer_overflow_irq_enable && timer_overflow_flag;
  wire edge_pending   = edge_pin_irq_enable && edge_pin_flag;
  wire port_pending   = port_change_irq_enable && port_change_flag;
  wire any_pending    = nvdata_pending || timer_pending || edge_pending || port_pending;

  assign core_irq_request = global_irq_enable && any_pending;

  // ****************************************************************
  // Program counter push on acknowledge
  // ****************************************************************
  wire take = core_irq_ack && core_irq_request;

  always_comb begin
    next_stack_push      = take;
    next_stack_push_data = stack_push_data;
    next_pc_pushed       = pc_pushed;
    if (take) begin
      next_stack_push_data = core_pc;
      next_pc_pushed       = core_pc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_push      <= 1'b0;
      stack_push_data <= iefr_pkg::pc_reset;
      pc_pushed       <= iefr_pkg::pc_reset;
    end else begin
      stack_push      <= next_stack_push;
      stack_push_data <= next_stack_push_data;
      pc_pushed       <= next_pc_pushed;
    end
  end

  // ****************************************************************
  // Event status, mask and interrupt line
  // ****************************************************************
  wire [iefr_pkg::ev_count-1:0] ev_now = {ev_nvdata, ev_timer, ev_edge, ev_port};

  // An event in the clearing cycle keeps its status bit set
  for (genvar k = 0; k < iefr_pkg::ev_count; k++) begin : g_status
    assign next_status[k] = ev_now[k] || (ev_status[k] && !(wr_status && pwdata[k]));
  end

  always_comb begin
    next_mask = ev_mask;
    if (wr_mask) begin
      next_mask = pwdata[iefr_pkg::ev_count-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status <= iefr_pkg::ev_reset;
      ev_mask   <= iefr_pkg::ev_reset;
    end else begin
      ev_status <= next_status;
      ev_mask   <= next_mask;
    end
  end

  assign irq = |(ev_status & ev_mask);

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Loaded in the setup cycle so that it stands through the access phase
  always_comb begin
    next_prdata = prdata;
    if (read_setup) begin
      next_prdata = read_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= iefr_pkg::rdata_reset;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule
`default_nettype wire

// ### dv/iefr_properties.sv
/* Port assertions for iefr_top.
   Assumes a bind from the bench onto iefr_top. */
`default_nettype none
module iefr_properties (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire iefr_pkg::iefr_events_type source_events,
  input wire logic                      core_irq_ack,
  input wire logic [12:0]               core_pc,
  input wire logic                      core_irq_request,
  input wire logic                      stack_push,
  input wire logic [12:0]               stack_push_data,
  input wire logic                      irq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire acc = psel & penable;
  wire wr  = acc & pwrite;
  wire mp  = paddr inside {iefr_pkg::addr_control_bank0, iefr_pkg::addr_control_bank1,
    iefr_pkg::addr_ev_status, iefr_pkg::addr_ev_mask, iefr_pkg::addr_pc_pushed};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_always: assert property (pready) else $error("pready low");
  chk_unmapped_err: assert property (acc && !mp |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access");
  chk_alias_mapped: assert property (acc && mp |-> !pslverr) else $error("mapped error");
  chk_push_on_ack: assert property (core_irq_ack && core_irq_request |=>
    stack_push && stack_push_data == $past(core_pc)) else $error("push missing");
  chk_push_cause: assert property (stack_push |-> $past(core_irq_ack && core_irq_request))
    else $error("stray push");
  chk_req_cause: assert property ($rose(core_irq_request) |-> $past(wr) ||
    $past(|source_events) || source_events.nvdata_write_done) else $error("stray request");
  chk_req_sticky: assert property ($fell(core_irq_request) |-> $past(wr) ||
    $fell(source_events.nvdata_write_done)) else $error("request dropped");
  chk_irq_cause: assert property ($rose(irq) |-> $past(wr) || $past(|source_events))
    else $error("stray irq");
  chk_irq_sticky: assert property ($fell(irq) |-> $past(wr)) else $error("irq dropped");
endmodule
`default_nettype wire

// ### dv/iefr_core_model.sv
/* Core model: acknowledges each new request once, PC keeps moving.
   Assumes the request level of iefr_top on pclk. */
`default_nettype none
module iefr_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        core_irq_request,
  output var  logic        core_irq_ack,
  output var  logic [12:0] core_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 1'b0;
      core_irq_ack <= 1'b0;
      core_pc <= 13'h1000;
    end else begin
      seen <= core_irq_request;
      core_irq_ack <= core_irq_request & ~seen;
      core_pc <= core_pc + 13'h0007;
    end
  end
endmodule
`default_nettype wire

// ### dv/interrupt_enable_flag_register_tb.sv
/* Self-checking bench for iefr_top over APB.
   Assumes iefr_pkg, iefr_top, iefr_core_model and iefr_properties. */
`default_nettype none
module interrupt_enable_flag_register_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ack, req, push, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb;
  logic [12:0] pc, pushd;
  logic [7:0]  en;
  logic        err;
  logic [12:0] exp_pc;
  int          acks, pushes;
  iefr_pkg::iefr_events_type ev;
  int fail_count, checks_done;
  iefr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .source_events(ev), .core_irq_ack(ack), .core_pc(pc),
    .core_irq_request(req), .stack_push(push), .stack_push_data(pushd), .irq);
  iefr_core_model core (.pclk, .presetn, .core_irq_request(req), .core_irq_ack(ack),
    .core_pc(pc));
  // The core model's acknowledge marks the PC that must be pushed
  always @(posedge pclk) begin
    if (ack === 1'b1) begin
      acks++;
      exp_pc = pc;
    end
    if (push === 1'b1) pushes++;
  end
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) begin
      fail_count++;
      close_out();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pulse(input logic [3:0] e);
    ev <= e;
    @(posedge pclk);
    ev <= 4'h0;
    @(posedge pclk);
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev, fail_count, checks_done} = '0;
    pstrb = 4'hf;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(0, iefr_pkg::addr_control_bank0, 32'h0);
    chk(rdv, 32'h0);
    chk(err, 1'b0);
    xfer(1, iefr_pkg::addr_control_bank1, 32'h5a);
    xfer(0, iefr_pkg::addr_control_bank0, 32'h0);
    chk(rdv, 32'h5a);
    chk(req, 1'b0);
    xfer(1, iefr_pkg::addr_control_bank0, 32'h0);
    pulse(4'h7);
    xfer(0, iefr_pkg::addr_control_bank1, 32'h0);
    chk(rdv, 32'h07);
    chk(req, 1'b0);
    $display("reset, alias and flag tests done");
    for (int i = 0; i < 3; i++) begin
      en = (8'h20 >> i) | (8'h04 >> i);
      xfer(1, iefr_pkg::addr_control_bank0, {24'h0, en | 8'h80});
      chk(req, 1'b1);
      xfer(1, iefr_pkg::addr_control_bank0, {24'h0, en});
      chk(req, 1'b0);
      xfer(1, iefr_pkg::addr_control_bank0, {24'h0, (8'h04 >> i) | 8'h80});
      chk(req, 1'b0);
    end
    xfer(1, iefr_pkg::addr_control_bank0, 32'hc0);
    ev <= 4'h8;
    repeat (2) @(posedge pclk);
    chk(req, 1'b1);
    ev <= 4'h0;
    repeat (2) @(posedge pclk);
    chk(req, 1'b0);
    xfer(1, iefr_pkg::addr_control_bank0, 32'ha0);
    pulse(4'h4);
    repeat (5) @(posedge pclk);
    chk(req, 1'b1);
    xfer(1, iefr_pkg::addr_control_bank0, 32'ha0);
    chk(req, 1'b0);
    $display("enable and request tests done");
    xfer(1, iefr_pkg::addr_ev_status, 32'hf);
    xfer(1, iefr_pkg::addr_ev_mask, 32'h4);
    chk(irq, 1'b0);
    pulse(4'h4);
    chk(irq, 1'b1);
    xfer(1, iefr_pkg::addr_ev_mask, 32'h0);
    chk(irq, 1'b0);
    xfer(1, iefr_pkg::addr_ev_mask, 32'h4);
    xfer(1, iefr_pkg::addr_ev_status, 32'h4);
    chk(irq, 1'b0);
    xfer(0, iefr_pkg::addr_pc_pushed, 32'h0);
    chk(rdv, {19'h0, exp_pc});
    chk(pushd, exp_pc);
    chk(pushes, acks);
    xfer(0, 12'h0f0, 32'h0);
    chk(rdv, 32'h0);
    chk(err, 1'b1);
    $display("interrupt and unmapped tests done");
    close_out();
  end
endmodule
bind iefr_top iefr_properties chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .source_events, .core_irq_ack, .core_pc, .core_irq_request,
  .stack_push, .stack_push_data, .irq);
`default_nettype wire
